// ---- core/sensor_consts.vh ----
/*
 * Constants of the status, heater and serial-code block: status field
 * positions, reset values, command codes, checksum settings.
 * Assumes inclusion by bare name from the design files under core/.
 */
`ifndef SENSOR_CONSTS_VH
`define SENSOR_CONSTS_VH

// ****************************************************************
// Status word field positions
// ****************************************************************
`define ST_ALERT_BIT 4
`define ST_ANY_ALERT_BIT 15
`define ST_HEATER_BIT 13
`define ST_TRK_RH_BIT 11
`define ST_TRK_T_BIT 10
`define ST_RH_HIGH_BIT 9
`define ST_RH_LOW_BIT 8
`define ST_T_HIGH_BIT 7
`define ST_T_LOW_BIT 6
`define ST_RESET_DET_BIT 4
`define ST_CRC_FAIL_BIT 0

// ****************************************************************
// Reset values and heater leg bit range
// ****************************************************************
`define RST_RESET_DET 1'b1
`define RST_HEATER_EN 1'b0
`define RST_CRC_FAIL 1'b0
`define RST_HEATER_SEL 14'h3fff
`define HEATER_LEG_TOP_BIT 13
`define HEATER_LEG_BOTTOM_BIT 0

// ****************************************************************
// Command codes (16-bit, most significant byte first)
// ****************************************************************
`define CMD_READ_STATUS 16'h0a01
`define CMD_CLEAR_STATUS 16'h0a02
`define CMD_HEATER_ON 16'h0a03
`define CMD_HEATER_OFF 16'h0a04
`define CMD_HEATER_SEL 16'h0a05
`define CMD_READ_SERIAL_HI 16'h0a06
`define CMD_READ_SERIAL_MID 16'h0a07
`define CMD_READ_SERIAL_LO 16'h0a08

// ****************************************************************
// Checksum and bus settings
// ****************************************************************
`define CRC_POLY 8'h31
`define CRC_INIT 8'hff
`define TARGET_ADDR 7'h44
`define IDLE_BYTE 8'hff

`endif

// ---- core/crc8_word.v ----
/*
 * Combinational CRC-8 over one 16-bit word, most significant bit first.
 * Assumes a stable word from flip-flops; result is purely combinational.
 */
`timescale 1ns/100ps
module crc8_word
#(
    parameter [7:0] POLY = 8'h31,
    parameter [7:0] INIT = 8'hff
)
(
    input wire [15:0] word_i,
    output reg [7:0] crc_o
);

    integer i;
    reg fb;

    // Bitwise shift through the polynomial
    always @*
    begin
        crc_o = INIT;
        fb = 1'b0;
        for (i = 15; i >= 0; i = i - 1)
        begin
            fb = crc_o[7] ^ word_i[i];
            crc_o = {crc_o[6:0], 1'b0};
            if (fb)
            begin
                crc_o = crc_o ^ POLY;
            end
        end
    end

endmodule

// ---- core/sensor_status_heater_id.v ----
/*
 * Two-wire serial target carrying the status word, heater control and
 * 48-bit serial-code readout of a humidity and temperature sensor.
 * Assumes scl_i and sda_i come from pins (synchronised here), alert
 * inputs and soft_reset_i come from logic on clk_i, and the wire level of
 * SDA is resolved outside from sda_o and sda_oe_o.
 */
// Behaviour
// - Bit 15 is OR of tracking/reset alerts
// - Bit 13 shows heater enabled, resets zero
// - Bit 11 humidity alert, mirrored on alert
// - Bit 10 temperature alert, mirrored on alert
// - Bits 9/8 humidity high/low alerts
// - Bits 7/6 temperature high/low alerts
// - Bit 4 set by resets, cleared by clear
// - Bit 0 holds last write checksum failure
// - Read-status and clear-status commands exist
// - Clear touches only reset and alert bits (15, 11..6, 4)
// - Heater enable and disable commands
// - Heater selection uses low 14 bits
// - Fixed 48-bit serial code, three reads
// - Each read: two bytes plus checksum
// - Reads deliver bytes 5..0, MSB first
`timescale 1ns/100ps
`include "sensor_consts.vh"
module sensor_status_heater_id
#(
    parameter [6:0] TARGET_ADDR = `TARGET_ADDR,
    parameter [47:0] SERIAL_CODE = 48'h0123456789ab // Arbitrary value
)
(
    input wire clk_i,
    input wire reset_n_i,
    input wire scl_i,
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe_o,
    input wire rh_high_i,
    input wire rh_low_i,
    input wire t_high_i,
    input wire t_low_i,
    input wire soft_reset_i,
    output wire alert_o,
    output wire heater_en_o,
    output reg [13:0] heater_drive_o
);

    // ****************************************************************
    // Local codes
    // ****************************************************************
    localparam [2:0] S_IDLE = 3'd0;
    localparam [2:0] S_RX = 3'd1;
    localparam [2:0] S_RACK = 3'd2;
    localparam [2:0] S_TX = 3'd3;
    localparam [2:0] S_TACK = 3'd4;
    localparam [2:0] S_TLOAD = 3'd5;

    localparam [2:0] SEL_NONE = 3'd0;
    localparam [2:0] SEL_STATUS = 3'd1;
    localparam [2:0] SEL_ID_HI = 3'd2;
    localparam [2:0] SEL_ID_MID = 3'd3;
    localparam [2:0] SEL_ID_LO = 3'd4;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg [1:0] scl_sync_r;
    reg [1:0] sda_sync_r;
    reg scl_d_r;
    reg sda_d_r;
    reg [2:0] state_r;
    reg [3:0] bit_cnt_r;
    reg [7:0] shreg_r;
    reg [2:0] byte_idx_r;
    reg [7:0] cmd_hi_r;
    reg [15:0] hdata_r;
    reg heat_cmd_r;
    reg read_mode_r;
    reg [2:0] rd_sel_r;
    reg [15:0] rd_word_r;
    reg [1:0] tx_idx_r;
    reg sda_oe_r;
    reg rh_high_r;
    reg rh_low_r;
    reg t_high_r;
    reg t_low_r;
    reg reset_det_r;
    reg heater_en_r;
    reg crc_fail_r;
    reg [13:0] heater_sel_r;
    reg [15:0] status_word;
    reg [15:0] rd_word_nxt;
    reg [7:0] tx_byte;
    wire scl_s;
    wire sda_s;
    wire scl_rise;
    wire scl_fall;
    wire start_det;
    wire stop_det;
    wire wr_done;
    wire cmd_done;
    wire [15:0] cmd_word;
    wire clr_cmd;
    wire heat_on_cmd;
    wire heat_off_cmd;
    wire crc_done;
    wire crc_ok;
    wire trk_rh;
    wire trk_t;
    wire [7:0] crc_rd;
    wire [7:0] crc_heat;
    wire [7:0] serial_byte_5;
    wire [7:0] serial_byte_4;
    wire [7:0] serial_byte_3;
    wire [7:0] serial_byte_2;
    wire [7:0] serial_byte_1;
    wire [7:0] serial_byte_0;

    // ****************************************************************
    // Pin synchronisers and bus events
    // ****************************************************************
    // Two flops per pin, then one more stage for edge detection
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            scl_sync_r <= 2'b11;
            sda_sync_r <= 2'b11;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else
        begin
            scl_sync_r <= {scl_sync_r[0], scl_i};
            sda_sync_r <= {sda_sync_r[0], sda_i};
            scl_d_r <= scl_sync_r[1];
            sda_d_r <= sda_sync_r[1];
        end
    end

    assign scl_s = scl_sync_r[1];
    assign sda_s = sda_sync_r[1];
    assign scl_rise = scl_s & ~scl_d_r;
    assign scl_fall = ~scl_s & scl_d_r;
    assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;

    // ****************************************************************
    // Command decode
    // ****************************************************************
    // A byte is complete at the falling clock after its eighth bit
    assign wr_done = (state_r == S_RX) & scl_fall & (bit_cnt_r == 4'd8);
    assign cmd_done = wr_done & ~read_mode_r & (byte_idx_r == 3'd2);
    assign cmd_word = {cmd_hi_r, shreg_r};
    assign clr_cmd = cmd_done & (cmd_word == `CMD_CLEAR_STATUS);
    assign heat_on_cmd = cmd_done & (cmd_word == `CMD_HEATER_ON);
    assign heat_off_cmd = cmd_done & (cmd_word == `CMD_HEATER_OFF);
    assign crc_done = wr_done & ~read_mode_r & heat_cmd_r & (byte_idx_r == 3'd5);
    assign crc_ok = (shreg_r == crc_heat);

    // ****************************************************************
    // Serial code and checksums
    // ****************************************************************
    assign serial_byte_5 = SERIAL_CODE[47:40];
    assign serial_byte_4 = SERIAL_CODE[39:32];
    assign serial_byte_3 = SERIAL_CODE[31:24];
    assign serial_byte_2 = SERIAL_CODE[23:16];
    assign serial_byte_1 = SERIAL_CODE[15:8];
    assign serial_byte_0 = SERIAL_CODE[7:0];

    // Checksum of the word being returned
    crc8_word #(.POLY(`CRC_POLY), .INIT(`CRC_INIT)) u_crc_rd
    (
        .word_i(rd_word_r),
        .crc_o(crc_rd)
    );

    // Checksum of the received heater selection word
    crc8_word #(.POLY(`CRC_POLY), .INIT(`CRC_INIT)) u_crc_heat
    (
        .word_i(hdata_r),
        .crc_o(crc_heat)
    );

    // ****************************************************************
    // Status word
    // ****************************************************************
    assign trk_rh = rh_high_r | rh_low_r;
    assign trk_t = t_high_r | t_low_r;

    // Reserved bits stay at the zero default
    always @*
    begin
        status_word = 16'h0000;
        status_word[`ST_ANY_ALERT_BIT] = trk_rh | trk_t | reset_det_r;
        status_word[`ST_HEATER_BIT] = heater_en_r;
        status_word[`ST_TRK_RH_BIT] = trk_rh;
        status_word[`ST_TRK_T_BIT] = trk_t;
        status_word[`ST_RH_HIGH_BIT] = rh_high_r;
        status_word[`ST_RH_LOW_BIT] = rh_low_r;
        status_word[`ST_T_HIGH_BIT] = t_high_r;
        status_word[`ST_T_LOW_BIT] = t_low_r;
        status_word[`ST_RESET_DET_BIT] = reset_det_r;
        status_word[`ST_CRC_FAIL_BIT] = crc_fail_r;
    end

    assign alert_o = trk_rh | trk_t | reset_det_r;

    // Sticky alerts: a set in the clearing cycle wins
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rh_high_r <= 1'b0;
            rh_low_r <= 1'b0;
            t_high_r <= 1'b0;
            t_low_r <= 1'b0;
            reset_det_r <= `RST_RESET_DET;
        end
        else
        begin
            rh_high_r <= (rh_high_r & ~clr_cmd) | rh_high_i;
            rh_low_r <= (rh_low_r & ~clr_cmd) | rh_low_i;
            t_high_r <= (t_high_r & ~clr_cmd) | t_high_i;
            t_low_r <= (t_low_r & ~clr_cmd) | t_low_i;
            reset_det_r <= (reset_det_r & ~clr_cmd) | soft_reset_i;
        end
    end

    // Heater state, selection and checksum result; clear leaves them
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            heater_en_r <= `RST_HEATER_EN;
            crc_fail_r <= `RST_CRC_FAIL;
            heater_sel_r <= `RST_HEATER_SEL;
        end
        else
        begin
            if (soft_reset_i)
            begin
                heater_en_r <= `RST_HEATER_EN;
                crc_fail_r <= `RST_CRC_FAIL;
                heater_sel_r <= `RST_HEATER_SEL;
            end
            else
            begin
                if (heat_on_cmd)
                begin
                    heater_en_r <= 1'b1;
                end
                else if (heat_off_cmd)
                begin
                    heater_en_r <= 1'b0;
                end
                if (crc_done)
                begin
                    crc_fail_r <= ~crc_ok;
                    if (crc_ok)
                    begin
                        heater_sel_r <= hdata_r[`HEATER_LEG_TOP_BIT:0];
                    end
                end
            end
        end
    end

    assign heater_en_o = heater_en_r;

    // Each selection bit powers one resistor leg while enabled
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            heater_drive_o <= 14'h0000;
        end
        else
        begin
            heater_drive_o <= heater_en_r ? heater_sel_r : 14'h0000;
        end
    end

    // ****************************************************************
    // Read word selection
    // ****************************************************************
    // Word snapshot taken when the read address is accepted
    always @*
    begin
        case (rd_sel_r)
            SEL_STATUS: rd_word_nxt = status_word;
            SEL_ID_HI: rd_word_nxt = {serial_byte_5, serial_byte_4};
            SEL_ID_MID: rd_word_nxt = {serial_byte_3, serial_byte_2};
            SEL_ID_LO: rd_word_nxt = {serial_byte_1, serial_byte_0};
            default: rd_word_nxt = 16'hffff;
        endcase
    end

    // Two data bytes then their checksum
    always @*
    begin
        case (tx_idx_r)
            2'd0: tx_byte = rd_word_r[15:8];
            2'd1: tx_byte = rd_word_r[7:0];
            2'd2: tx_byte = crc_rd;
            default: tx_byte = `IDLE_BYTE;
        endcase
    end

    // ****************************************************************
    // Serial target state machine
    // ****************************************************************
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_r <= S_IDLE;
            bit_cnt_r <= 4'd0;
            shreg_r <= 8'h00;
            byte_idx_r <= 3'd0;
            cmd_hi_r <= 8'h00;
            hdata_r <= 16'h0000;
            heat_cmd_r <= 1'b0;
            read_mode_r <= 1'b0;
            rd_sel_r <= SEL_NONE;
            rd_word_r <= 16'h0000;
            tx_idx_r <= 2'd0;
            sda_oe_r <= 1'b0;
        end
        else if (start_det)
        begin
            state_r <= S_RX;
            bit_cnt_r <= 4'd0;
            byte_idx_r <= 3'd0;
            read_mode_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end
        else if (stop_det)
        begin
            state_r <= S_IDLE;
            sda_oe_r <= 1'b0;
        end
        else
        begin
            case (state_r)
                S_RX:
                begin
                    if (scl_rise && bit_cnt_r != 4'd8)
                    begin
                        shreg_r <= {shreg_r[6:0], sda_s};
                        bit_cnt_r <= bit_cnt_r + 4'd1;
                    end
                    else if (wr_done)
                    begin
                        state_r <= S_RACK;
                        sda_oe_r <= 1'b1;
                        if (byte_idx_r != 3'd7)
                        begin
                            byte_idx_r <= byte_idx_r + 3'd1;
                        end
                        if (byte_idx_r == 3'd0)
                        begin
                            if (shreg_r[7:1] != TARGET_ADDR)
                            begin
                                state_r <= S_IDLE;
                                sda_oe_r <= 1'b0;
                            end
                            read_mode_r <= shreg_r[0];
                            rd_word_r <= rd_word_nxt;
                            tx_idx_r <= 2'd0;
                        end
                        else if (!read_mode_r)
                        begin
                            case (byte_idx_r)
                                3'd1: cmd_hi_r <= shreg_r;
                                3'd3: hdata_r[15:8] <= shreg_r;
                                3'd4: hdata_r[7:0] <= shreg_r;
                                default: cmd_hi_r <= cmd_hi_r;
                            endcase
                        end
                        if (cmd_done)
                        begin
                            heat_cmd_r <= (cmd_word == `CMD_HEATER_SEL);
                            case (cmd_word)
                                `CMD_READ_STATUS: rd_sel_r <= SEL_STATUS;
                                `CMD_READ_SERIAL_HI: rd_sel_r <= SEL_ID_HI;
                                `CMD_READ_SERIAL_MID: rd_sel_r <= SEL_ID_MID;
                                `CMD_READ_SERIAL_LO: rd_sel_r <= SEL_ID_LO;
                                default: rd_sel_r <= SEL_NONE;
                            endcase
                        end
                    end
                end
                S_RACK:
                begin
                    if (scl_fall)
                    begin
                        bit_cnt_r <= 4'd0;
                        if (read_mode_r)
                        begin
                            state_r <= S_TX;
                            shreg_r <= tx_byte;
                            sda_oe_r <= ~tx_byte[7];
                        end
                        else
                        begin
                            state_r <= S_RX;
                            sda_oe_r <= 1'b0;
                        end
                    end
                end
                S_TX:
                begin
                    if (scl_fall)
                    begin
                        if (bit_cnt_r == 4'd7)
                        begin
                            state_r <= S_TACK;
                            sda_oe_r <= 1'b0;
                        end
                        else
                        begin
                            shreg_r <= {shreg_r[6:0], 1'b0};
                            sda_oe_r <= ~shreg_r[6];
                            bit_cnt_r <= bit_cnt_r + 4'd1;
                        end
                    end
                end
                S_TACK:
                begin
                    if (scl_rise)
                    begin
                        state_r <= sda_s ? S_IDLE : S_TLOAD;
                        if (tx_idx_r != 2'd3)
                        begin
                            tx_idx_r <= tx_idx_r + 2'd1;
                        end
                    end
                end
                S_TLOAD:
                begin
                    if (scl_fall)
                    begin
                        state_r <= S_TX;
                        bit_cnt_r <= 4'd0;
                        shreg_r <= tx_byte;
                        sda_oe_r <= ~tx_byte[7];
                    end
                end
                default:
                begin
                    state_r <= S_IDLE;
                    sda_oe_r <= 1'b0;
                end
            endcase
        end
    end

    // Open-drain data line: only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe_o = sda_oe_r;

endmodule

// ---- testbench/bus_host_model.sv ----
/*
 * Two-wire bus host model: drives SCL and pulls SDA low as open drain.
 * Assumes the bench resolves SDA with a pull-up and calls the tasks.
 */
`timescale 1ns/100ps
module bus_host_model
(
    input wire clk_i,
    input wire sda_line_i,
    output reg scl_o,
    output reg pull_low_o,
    output reg rx_valid_o,
    output reg [7:0] rx_byte_o
);
    reg ack_r;
    // SCL stands high and SDA is released between frames
    initial
    begin
        scl_o = 1'b1;
        pull_low_o = 1'b0;
        rx_valid_o = 1'b0;
        rx_byte_o = 8'h00;
    end
    task tick(input integer n);
        repeat (n) @(posedge clk_i);
    endtask
    // SDA moves only while SCL is low; 12 clocks a bit
    task bit_out(input b);
        pull_low_o <= !b;
        tick(3);
        scl_o <= 1'b1;
        tick(6);
        scl_o <= 1'b0;
        tick(3);
    endtask
    task bit_in(output b);
        pull_low_o <= 1'b0;
        tick(3);
        scl_o <= 1'b1;
        tick(3);
        b = sda_line_i;
        tick(3);
        scl_o <= 1'b0;
        tick(3);
    endtask
    // Start or repeated start: SDA falls while SCL is high
    task start;
        pull_low_o <= 1'b0;
        tick(3);
        scl_o <= 1'b1;
        tick(3);
        pull_low_o <= 1'b1;
        tick(3);
        scl_o <= 1'b0;
        tick(3);
    endtask
    // Stop: SDA rises while SCL is high
    task stop;
        pull_low_o <= 1'b1;
        tick(3);
        scl_o <= 1'b1;
        tick(3);
        pull_low_o <= 1'b0;
        tick(6);
    endtask
    task wr_byte(input [7:0] d);
        integer i;
        for (i = 7; i >= 0; i = i - 1)
            bit_out(d[i]);
        bit_in(ack_r);
    endtask
    // Reads a byte, answers ack or nack, reports it for one cycle
    task rd_byte(input ack);
        integer i;
        reg b;
        for (i = 7; i >= 0; i = i - 1)
        begin
            bit_in(b);
            rx_byte_o[i] <= b;
        end
        bit_out(!ack);
        rx_valid_o <= 1'b1;
        tick(1);
        rx_valid_o <= 1'b0;
    endtask
endmodule

// ---- testbench/sensor_status_heater_id_monitor.sv ----
/*
 * Port checks of the status, heater and serial-code block.
 * Assumes binding to the block's top module; one clock domain.
 */
`timescale 1ns/100ps
module sensor_status_heater_id_monitor
(
    input wire clk_i,
    input wire reset_n_i,
    input wire scl_i,
    input wire sda_i,
    input wire sda_o,
    input wire sda_oe_o,
    input wire rh_high_i,
    input wire rh_low_i,
    input wire t_high_i,
    input wire t_low_i,
    input wire soft_reset_i,
    input wire alert_o,
    input wire heater_en_o,
    input wire [13:0] heater_drive_o
);
    reg any_src_r;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    // Alert source seen last cycle
    always @(posedge clk_i or negedge reset_n_i)
        if (!reset_n_i)
            any_src_r <= 1'b0;
        else
            any_src_r <= rh_high_i | rh_low_i | t_high_i | t_low_i | soft_reset_i;
    // ****************
    // Port relations
    // ****************
    a_reset_state: assert property ($rose(reset_n_i) |->
        alert_o && !heater_en_o && !sda_oe_o) else $error("state after reset");
    a_sda_low: assert property (sda_o == 1'b0) else $error("sda value not low");
    a_drive_off: assert property (!heater_en_o |=> heater_drive_o == 14'h0)
        else $error("heater legs driven while off");
    a_soft_reset: assert property (soft_reset_i |-> ##[1:2] (alert_o && !heater_en_o))
        else $error("soft reset not seen");
    a_rh_alert: assert property (rh_high_i || rh_low_i |-> ##[1:2] alert_o)
        else $error("humidity alert missing");
    a_t_alert: assert property (t_high_i || t_low_i |-> ##[1:2] alert_o)
        else $error("temperature alert missing");
    a_alert_sticky: assert property ($fell(alert_o) |-> !any_src_r)
        else $error("alert dropped while source active");
    a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i))
        else $error("sda drive changed with scl high");
    cover property ($rose(heater_en_o));
    cover property ($fell(alert_o));
    cover property ($rose(sda_oe_o));
endmodule
bind sensor_status_heater_id sensor_status_heater_id_monitor mon
(
    .clk_i(clk_i), .reset_n_i(reset_n_i), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .rh_high_i(rh_high_i), .rh_low_i(rh_low_i),
    .t_high_i(t_high_i), .t_low_i(t_low_i), .soft_reset_i(soft_reset_i),
    .alert_o(alert_o), .heater_en_o(heater_en_o), .heater_drive_o(heater_drive_o)
);

// ---- testbench/sensor_status_heater_id_test.sv ----
/*
 * Self-checking bench of the status, heater and serial-code block.
 * Assumes the host model and monitor are compiled before it.
 */
`timescale 1ns/100ps
`include "sensor_consts.vh"
module sensor_status_heater_id_test;
    localparam [47:0] CODE = 48'h0123456789ab; // Arbitrary value
    reg clk_i, reset_n_i, soft_reset_i;
    reg [3:0] src;
    reg [31:0] seed, cycles;
    reg [15:0] w;
    reg [7:0] exp_q[$];
    integer errors, tests_run, k;
    wire scl, pull_low, rx_valid, sda_oe, alert, heater_en;
    wire [7:0] rx_byte;
    wire [13:0] drive;
    wire sda = ~(pull_low | sda_oe);
    sensor_status_heater_id #(.SERIAL_CODE(CODE)) dut
    (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .scl_i(scl), .sda_i(sda), .sda_o(),
        .sda_oe_o(sda_oe), .rh_high_i(src[3]), .rh_low_i(src[2]), .t_high_i(src[1]),
        .t_low_i(src[0]), .soft_reset_i(soft_reset_i), .alert_o(alert),
        .heater_en_o(heater_en), .heater_drive_o(drive)
    );
    bus_host_model host
    (
        .clk_i(clk_i), .sda_line_i(sda), .scl_o(scl), .pull_low_o(pull_low),
        .rx_valid_o(rx_valid), .rx_byte_o(rx_byte)
    );
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    endfunction
    // Word checksum: poly 31, init ff, MSB first
    function [7:0] crc8(input [15:0] d);
        integer i;
        reg [7:0] c;
        c = 8'hff;
        for (i = 15; i >= 0; i = i - 1)
            c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ 8'h31) : {c[6:0], 1'b0};
        crc8 = c;
    endfunction
    task check_byte(input [7:0] got, input [7:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask
    task check_level(input [13:0] got, input [13:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("wrong value at %0t: port %h, expected %h", $time, got, exp);
        end
    endtask
    task complete_run;
        $display("errors %0d, comparisons %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0 && exp_q.size() == 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Oldest expected byte checked on each host report
    always @(posedge clk_i)
        if (rx_valid === 1'b1)
            check_byte(rx_byte, exp_q.size() != 0 ? exp_q.pop_front() : 8'hxx);
    // Cuts a hang short
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 32'd60000)
        begin
            errors = errors + 1;
            complete_run;
        end
    end
    task send_cmd(input [15:0] cmd);
        host.start;
        host.wr_byte({`TARGET_ADDR, 1'b0});
        host.wr_byte(cmd[15:8]);
        host.wr_byte(cmd[7:0]);
    endtask
    task command(input [15:0] cmd);
        send_cmd(cmd);
        host.stop;
    endtask
    task write_sel(input [15:0] d, input [7:0] c);
        send_cmd(`CMD_HEATER_SEL);
        host.wr_byte(d[15:8]);
        host.wr_byte(d[7:0]);
        host.wr_byte(c);
        host.stop;
    endtask
    // Expected bytes queued before the host clocks them in
    task read_word(input [15:0] cmd, input [15:0] exp);
        send_cmd(cmd);
        host.start;
        host.wr_byte({`TARGET_ADDR, 1'b1});
        exp_q.push_back(exp[15:8]);
        exp_q.push_back(exp[7:0]);
        exp_q.push_back(crc8(exp));
        host.rd_byte(1'b1);
        host.rd_byte(1'b1);
        host.rd_byte(1'b0);
        host.stop;
    endtask
    // Main sequence
    initial
    begin
        reset_n_i = 1'b0;
        soft_reset_i = 1'b0;
        src = 4'h0;
        seed = 32'd26329;
        cycles = 32'd0;
        errors = 0;
        tests_run = 0;
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        check_level({11'h0, alert, heater_en, sda_oe}, 14'h4);
        read_word(`CMD_READ_STATUS, 16'h8010);
        command(`CMD_CLEAR_STATUS);
        read_word(`CMD_READ_STATUS, 16'h0000);
        command(`CMD_HEATER_ON);
        check_level(drive, 14'h3fff);
        read_word(`CMD_READ_STATUS, 16'h2000);
        for (k = 0; k < 3; k = k + 1)
        begin
            w = (k == 0) ? 16'h3fff : (k == 1) ? 16'h03ff : 16'h009f;
            write_sel(w, (k == 0) ? 8'h06 : (k == 1) ? 8'h00 : 8'h96);
            check_level(drive, w[13:0]);
        end
        write_sel(16'h0155, crc8(16'h0155) ^ 8'h5a);
        check_level(drive, 14'h009f);
        read_word(`CMD_READ_STATUS, 16'h2001);
        command(`CMD_CLEAR_STATUS);
        read_word(`CMD_READ_STATUS, 16'h2001);
        seed = xs(seed);
        w = {2'b00, seed[13:0]};
        write_sel(w, crc8(w));
        check_level(drive, w[13:0]);
        read_word(`CMD_READ_STATUS, 16'h2000);
        for (k = 0; k < 4; k = k + 1)
        begin
            seed = xs(seed);
            src[k] <= 1'b1;
            repeat (seed[1:0] + 1) @(posedge clk_i);
            src[k] <= 1'b0;
            repeat (3) @(posedge clk_i);
            check_level({13'h0, alert}, 14'h1);
            w = 16'ha000 | (16'h0040 << k) | ((k > 1) ? 16'h0800 : 16'h0400);
            read_word(`CMD_READ_STATUS, w);
            command(`CMD_CLEAR_STATUS);
            check_level({13'h0, alert}, 14'h0);
        end
        read_word(`CMD_READ_SERIAL_HI, CODE[47:32]);
        read_word(`CMD_READ_SERIAL_MID, CODE[31:16]);
        read_word(`CMD_READ_SERIAL_LO, CODE[15:0]);
        command(`CMD_HEATER_OFF);
        check_level({13'h0, heater_en}, 14'h0);
        check_level(drive, 14'h0);
        soft_reset_i <= 1'b1;
        @(posedge clk_i);
        soft_reset_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        check_level({13'h0, alert}, 14'h1);
        read_word(`CMD_READ_STATUS, 16'h8010);
        repeat (20) @(posedge clk_i);
        complete_run;
    end
endmodule
